// ===== design/pdx_consts.svh
// Constants for the paged data address extender: register offsets, field
// positions, reset values and page boundary values.
// Assumes byte addressing on the Avalon-MM register port, one word per register.
`ifndef PDX_CONSTS_SVH
`define PDX_CONSTS_SVH

`define PDX_OFF_READ_PAGE   5'h00
`define PDX_OFF_WRITE_PAGE  5'h04
`define PDX_OFF_STATUS      5'h08
`define PDX_OFF_MASK        5'h0c
`define PDX_OFF_LAST_ADDR   5'h10

`define PDX_RPAG_W          10
`define PDX_WPAG_W          9
`define PDX_PAGE_RESET      10'h001
`define PDX_PAGE_ZERO       10'h000
`define PDX_PAGE_EDS_LAST   10'h1ff
`define PDX_PAGE_PS_FIRST   10'h200
`define PDX_PAGE_PS_LOW_END 10'h2ff
`define PDX_PAGE_PS_HI_LAST 10'h3ff

`define PDX_ST_W            2
`define PDX_ST_TRAP         0
`define PDX_ST_STEP         1

`endif

// ===== design/pdx_pkg.sv
// Types shared by the paged data address extender.
// Assumes the effective address unit encodes its addressing mode as below.
package pdx_pkg;

    typedef enum logic [2:0] {
        PDX_MODE_DIRECT,
        PDX_MODE_INDIRECT,
        PDX_MODE_PRE_MOD,
        PDX_MODE_POST_MOD,
        PDX_MODE_REG_OFFSET,
        PDX_MODE_MODULO,
        PDX_MODE_BIT_REV
    } pdx_mode_t;

endpackage

// ===== design/pdx_page_step.sv
// Page step on an effective address overflow or underflow.
// Assumes the caller only uses the result for pre- or post-modified accesses.
`timescale 1ns/1ns
`include "pdx_consts.svh"

module pdx_page_step
    import pdx_pkg::*;
(
    input  wire logic [9:0] page,
    input  wire logic       is_write,
    input  wire logic       ovf,
    input  wire logic       unf,
    output logic      [9:0] page_next,
    output logic            ea15_next
);

    always_comb begin
        page_next = page;
        ea15_next = 1'b1;
        if (page == `PDX_PAGE_ZERO) begin
            // Page 0 in the window traps anyway; never wrap it round
            ea15_next = 1'b1;
        end else if (ovf) begin
            // last pages fall back to base space
            if (page == `PDX_PAGE_EDS_LAST || (!is_write && page == `PDX_PAGE_PS_HI_LAST)) begin
                ea15_next = 1'b0;
            end else begin
                // step up; 0x2ff rolls into 0x300
                page_next = page + 10'h001;
            end
        end else if (unf) begin
            // first pages fall back to base space
            if (page == `PDX_PAGE_RESET || (!is_write && page == `PDX_PAGE_PS_FIRST)) begin
                ea15_next = 1'b0;
            end else begin
                // step down; 0x300 returns to 0x2ff
                page_next = page - 10'h001;
            end
        end
    end

endmodule

// ===== design/pdx_irq_ctrl.sv
// Sticky event status with write-one-to-clear, mask, and one level interrupt.
// Assumes events and clears are single-cycle strobes on the system clock.
`timescale 1ns/1ns
`include "pdx_consts.svh"

module pdx_irq_ctrl
    import pdx_pkg::*;
(
    input  wire logic                  sys_clk,
    input  wire logic                  srst,
    input  wire logic [`PDX_ST_W-1:0]  event_set,
    input  wire logic [`PDX_ST_W-1:0]  clear_bits,
    input  wire logic                  mask_wr,
    input  wire logic [`PDX_ST_W-1:0]  mask_data,
    output logic      [`PDX_ST_W-1:0]  status_q,
    output logic      [`PDX_ST_W-1:0]  mask_q,
    output logic                       irq_q
);

    // A set in the clearing cycle wins so no event is lost
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~clear_bits) | event_set;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mask_q <= '0;
        end else if (mask_wr) begin
            mask_q <= mask_data;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= |(((status_q & ~clear_bits) | event_set) & mask_q);
        end
    end

endmodule

// ===== design/pdx_addr_ext.sv
// Paged data address extender: forms 24-bit extended data and program window
// addresses from a 16-bit effective address and the read/write page registers.
// Assumes the effective address unit runs on sys_clk and flags carry/borrow
// of its pre/post modification; registers are reached over Avalon-MM.
`timescale 1ns/1ns
`include "pdx_consts.svh"

module pdx_addr_ext
    import pdx_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        srst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        ea_valid,
    input  wire logic        ea_write,
    input  wire logic [15:0] ea_value,
    input  wire logic        ea_orig_upper,
    input  wire pdx_mode_t   ea_mode,
    input  wire logic        ea_overflow,
    input  wire logic        ea_underflow,
    input  wire logic        ea_ps_write,
    output logic             mem_valid,
    output logic             mem_write,
    output logic             mem_psv,
    output logic      [23:0] mem_addr,
    output logic             addr_trap,
    output logic             irq
);

    logic [`PDX_RPAG_W-1:0] read_page_select_q;
    logic [`PDX_WPAG_W-1:0] write_page_select_q;
    logic [9:0]             active_page_select;
    logic [9:0]             step_page;
    logic                   step_ea15;
    logic                   step_en;
    logic                   hold_en;
    logic                   ea15_eff;
    logic [9:0]             page_eff;
    logic                   trap_d;
    logic                   bus_req;
    logic                   bus_wr;
    logic                   rpag_bus_wr;
    logic                   wpag_bus_wr;
    logic [31:0]            rdata_d;
    logic [`PDX_ST_W-1:0]   status_q;
    logic [`PDX_ST_W-1:0]   mask_q;
    logic [`PDX_ST_W-1:0]   clear_bits;
    logic [`PDX_ST_W-1:0]   event_set;
    logic                   wait_q;
    logic [31:0]            readdata_q;
    logic                   mem_valid_q;
    logic                   mem_write_q;
    logic                   mem_psv_q;
    logic [23:0]            mem_addr_q;
    logic                   trap_q;
    logic                   irq_q;

    function automatic logic is_reg(input logic [4:0] addr, input logic [4:0] off);
        is_reg = (addr == off);
    endfunction

    function automatic logic is_paged_mode(input pdx_mode_t mode);
        is_paged_mode = (mode == PDX_MODE_PRE_MOD) || (mode == PDX_MODE_POST_MOD);
    endfunction

    // Register bus: one wait cycle, then the access completes
    assign bus_req     = avs_read | avs_write;
    assign bus_wr      = avs_write & ~wait_q;
    assign rpag_bus_wr = bus_wr && is_reg(avs_address, `PDX_OFF_READ_PAGE);
    assign wpag_bus_wr = bus_wr && is_reg(avs_address, `PDX_OFF_WRITE_PAGE);
    assign clear_bits  = (bus_wr && is_reg(avs_address, `PDX_OFF_STATUS))
                         ? avs_writedata[`PDX_ST_W-1:0] : '0;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            wait_q <= 1'b1;
        end else begin
            wait_q <= ~(bus_req & wait_q);
        end
    end

    always_comb begin
        rdata_d = 32'h0000_0000;
        case (avs_address)
            `PDX_OFF_READ_PAGE:  rdata_d[`PDX_RPAG_W-1:0] = read_page_select_q;
            `PDX_OFF_WRITE_PAGE: rdata_d[`PDX_WPAG_W-1:0] = write_page_select_q;
            `PDX_OFF_STATUS:     rdata_d[`PDX_ST_W-1:0] = status_q;
            `PDX_OFF_MASK:       rdata_d[`PDX_ST_W-1:0] = mask_q;
            `PDX_OFF_LAST_ADDR:  rdata_d[23:0] = mem_addr_q;
            default:             rdata_d = 32'h0000_0000;
        endcase
    end

    // Read data are captured on the first edge so they stand when the wait ends
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            readdata_q <= 32'h0000_0000;
        end else if (avs_read & wait_q) begin
            readdata_q <= rdata_d;
        end
    end

    assign active_page_select = ea_write ? {1'b0, write_page_select_q} : read_page_select_q;

    pdx_page_step u_step (
        .page      (active_page_select),
        .is_write  (ea_write),
        .ovf       (ea_overflow),
        .unf       (ea_underflow),
        .page_next (step_page),
        .ea15_next (step_ea15)
    );

    always_comb begin
        step_en  = ea_valid && ea_orig_upper && (ea_overflow || ea_underflow)
                   && is_paged_mode(ea_mode);
        hold_en  = ea_valid && ea_orig_upper && (ea_overflow || ea_underflow)
                   && (ea_mode == PDX_MODE_REG_OFFSET || ea_mode == PDX_MODE_MODULO
                       || ea_mode == PDX_MODE_BIT_REV);
        ea15_eff = ea_value[15];
        if (step_en) begin
            ea15_eff = step_ea15;
        end else if (hold_en) begin
            ea15_eff = 1'b1;
        end
        page_eff = step_en ? step_page : active_page_select;
        // Page zero cannot be reached by stepping or software; kept as a guard
        // program-space write or page zero in window
        trap_d   = ea_valid && ((ea_write && ea_ps_write)
                   || (ea15_eff && page_eff == `PDX_PAGE_ZERO));
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            read_page_select_q <= `PDX_PAGE_RESET;
        end else if (rpag_bus_wr) begin
            if (avs_writedata[`PDX_RPAG_W-1:0] != `PDX_PAGE_ZERO) begin
                read_page_select_q <= avs_writedata[`PDX_RPAG_W-1:0];
            end
        end else if (step_en && !ea_write) begin
            read_page_select_q <= step_page;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            write_page_select_q <= 9'(`PDX_PAGE_RESET);
        end else if (wpag_bus_wr) begin
            if (avs_writedata[`PDX_WPAG_W-1:0] != `PDX_PAGE_ZERO) begin
                write_page_select_q <= avs_writedata[`PDX_WPAG_W-1:0];
            end
        end else if (step_en && ea_write) begin
            write_page_select_q <= step_page[`PDX_WPAG_W-1:0];
        end
    end

    // trap suppresses the access for that cycle
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mem_valid_q <= 1'b0;
            trap_q      <= 1'b0;
        end else begin
            mem_valid_q <= ea_valid & ~trap_d;
            trap_q      <= trap_d;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            mem_write_q <= 1'b0;
            mem_psv_q   <= 1'b0;
            mem_addr_q  <= 24'h00_0000;
        end else if (ea_valid && !trap_d) begin
            mem_write_q <= ea_write;
            if (!ea15_eff) begin
                // lower half stays in page zero
                mem_psv_q  <= 1'b0;
                mem_addr_q <= {8'h00, ea15_eff, ea_value[14:0]};
            end else begin
                mem_addr_q <= {page_eff[8:0], ea_value[14:0]};
                // read page 0x200 and up reads program space
                mem_psv_q  <= !ea_write && page_eff[9];
            end
        end
    end

    assign event_set = {step_en, trap_d};

    pdx_irq_ctrl u_irq (
        .sys_clk    (sys_clk),
        .srst       (srst),
        .event_set  (event_set),
        .clear_bits (clear_bits),
        .mask_wr    (bus_wr && is_reg(avs_address, `PDX_OFF_MASK)),
        .mask_data  (avs_writedata[`PDX_ST_W-1:0]),
        .status_q   (status_q),
        .mask_q     (mask_q),
        .irq_q      (irq_q)
    );

    assign avs_readdata    = readdata_q;
    assign avs_waitrequest = wait_q;
    assign mem_valid       = mem_valid_q;
    assign mem_write       = mem_write_q;
    assign mem_psv         = mem_psv_q;
    assign mem_addr        = mem_addr_q;
    assign addr_trap       = trap_q;
    assign irq             = irq_q;

    // Checks
    AST_RESET_PAGES: assert property (@(posedge sys_clk)
        srst |=> read_page_select_q == `PDX_PAGE_RESET
                 && write_page_select_q == 9'h001)
        else $error("Page registers not one after reset");

    AST_ZERO_WRITE_KEEPS: assert property (@(posedge sys_clk) disable iff (srst)
        rpag_bus_wr && avs_writedata[9:0] == 10'h000 |=> $stable(read_page_select_q))
        else $error("Zero write changed read page");

    AST_TRAP_SUPPRESS: assert property (@(posedge sys_clk) disable iff (srst)
        ea_valid && trap_d |=> addr_trap && !mem_valid ##1 !addr_trap || $past(trap_d))
        else $error("Trap not a suppressing pulse");

    AST_PAGE0_TRAP: assert property (@(posedge sys_clk) disable iff (srst)
        ea_valid && ea15_eff && page_eff == 10'h000 |=> addr_trap)
        else $error("Page zero window access did not trap");

    AST_PS_WRITE_TRAP: assert property (@(posedge sys_clk) disable iff (srst)
        ea_valid && ea_write && ea_ps_write |=> addr_trap && !mem_valid)
        else $error("Program space write did not trap");

    AST_BASE_PAGE0: assert property (@(posedge sys_clk) disable iff (srst)
        ea_valid && !ea15_eff && !trap_d |=> mem_valid && mem_addr[23:15] == 9'h000)
        else $error("Lower base address left page zero");

    AST_WRITE_ADDR: assert property (@(posedge sys_clk) disable iff (srst)
        ea_valid && ea_write && ea_value[15] && !step_en && !hold_en && !trap_d
        |=> mem_addr == {$past(write_page_select_q), $past(ea_value[14:0])} && mem_write)
        else $error("Write window address wrong");

    AST_PSV_READ: assert property (@(posedge sys_clk) disable iff (srst)
        ea_valid && !ea_write && ea15_eff && page_eff >= 10'h200 && !trap_d |=> mem_psv)
        else $error("High read page not sent to program space");

    AST_PSV_STEP_UP: assert property (@(posedge sys_clk) disable iff (srst)
        step_en && !ea_write && ea_overflow && read_page_select_q == 10'h2ff && !rpag_bus_wr
        |=> read_page_select_q == 10'h300 && mem_addr[23:15] == 9'h100)
        else $error("Read page 0x2ff did not step to 0x300");

    AST_EDS_LAST_FALLBACK: assert property (@(posedge sys_clk) disable iff (srst)
        step_en && ea_overflow && active_page_select == 10'h1ff && !rpag_bus_wr && !wpag_bus_wr
        && !trap_d |=> $stable(read_page_select_q) && $stable(write_page_select_q)
            && mem_addr[23:15] == 9'h000)
        else $error("Last page overflow did not fall back to base space");

    AST_OFFSET_HOLD: assert property (@(posedge sys_clk) disable iff (srst)
        hold_en && !rpag_bus_wr && !wpag_bus_wr
        |=> $stable(read_page_select_q) && $stable(write_page_select_q))
        else $error("Non-linear mode changed the page");

    AST_READ_ADDR: assert property (@(posedge sys_clk) disable iff (srst)
        ea_valid && !ea_write && ea_value[15]
        && !read_page_select_q[9] && !step_en && !hold_en && !trap_d
        |=> mem_addr == {$past(read_page_select_q[8:0]), $past(ea_value[14:0])}
        && !mem_psv)
        else $error("Read window address wrong");

    AST_STEP_UP: assert property (@(posedge sys_clk) disable iff (srst)
        step_en && ea_overflow && !ea_write && !rpag_bus_wr
        && read_page_select_q != 10'h000
        && read_page_select_q != 10'h1ff && read_page_select_q != 10'h3ff
        |=> read_page_select_q == $past(read_page_select_q) + 10'h001)
        else $error("Overflow did not advance the read page");

    AST_STEP_DOWN: assert property (@(posedge sys_clk) disable iff (srst)
        step_en && ea_underflow && !ea_overflow && !ea_write
        && !rpag_bus_wr
        && read_page_select_q > 10'h001 && read_page_select_q != 10'h200
        |=> read_page_select_q == $past(read_page_select_q) - 10'h001)
        else $error("Underflow did not step the read page back");

    AST_UNDER_FALLBACK: assert property (@(posedge sys_clk) disable iff (srst)
        step_en && ea_underflow && !ea_overflow && !ea_write
        && !rpag_bus_wr && !trap_d
        && (read_page_select_q == 10'h001 || read_page_select_q == 10'h200)
        |=> $stable(read_page_select_q) && mem_addr[23:15] == 9'h000 && !mem_psv)
        else $error("First page underflow did not fall back");

    AST_BUS_ONE_WAIT: assert property (@(posedge sys_clk) disable iff (srst)
        avs_waitrequest && (avs_read || avs_write)
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("Register access not one wait cycle");

    AST_WRITE_KEEPS_RPAGE: assert property (@(posedge sys_clk) disable iff (srst)
        ea_valid && ea_write && !rpag_bus_wr |=> $stable(read_page_select_q))
        else $error("Write access moved the read page");

    AST_WRITE_NOT_PS: assert property (@(posedge sys_clk) disable iff (srst)
        ea_valid && ea_write && !trap_d |=> mem_valid && mem_write && !mem_psv)
        else $error("Write access reached program space");

    CVR_PAGE_STEP: cover property (@(posedge sys_clk) disable iff (srst)
        step_en && step_ea15);
    CVR_TRAP: cover property (@(posedge sys_clk) disable iff (srst) addr_trap);
    CVR_PSV_READ: cover property (@(posedge sys_clk) disable iff (srst) mem_valid && mem_psv);
    CVR_BUS_WRITE: cover property (@(posedge sys_clk) disable iff (srst) wpag_bus_wr);
    CVR_UNDER_STEP: cover property (@(posedge sys_clk) disable iff (srst) step_en && ea_underflow);

endmodule

// ===== verification/pdx_cpu_model.sv
// Model of the CPU effective address unit that feeds the extender.
// Assumes the bench calls access() from a process synchronised to sys_clk.
`timescale 1ns/1ns

module pdx_cpu_model
    import pdx_pkg::*;
(
    input  wire logic        sys_clk,
    output logic             ea_valid,
    output logic             ea_write,
    output logic      [15:0] ea_value,
    output logic             ea_orig_upper,
    output pdx_mode_t        ea_mode,
    output logic             ea_overflow,
    output logic             ea_underflow,
    output logic             ea_ps_write
);
    initial begin
        ea_valid = 1'b0;
        ea_write = 1'b0;
        ea_value = 16'h0000;
        ea_orig_upper = 1'b0;
        ea_mode = PDX_MODE_DIRECT;
        ea_overflow = 1'b0;
        ea_underflow = 1'b0;
        ea_ps_write = 1'b0;
    end

    // One access, valid for exactly one edge
    task automatic access(input logic wr, input logic [15:0] va, input logic up,
                          input pdx_mode_t md, input logic ov, input logic un,
                          input logic pgw);
        @(posedge sys_clk);
        ea_valid <= 1'b1;
        ea_write <= wr;
        ea_value <= va;
        ea_orig_upper <= up;
        ea_mode <= md;
        ea_overflow <= ov;
        ea_underflow <= un;
        ea_ps_write <= pgw;
        @(posedge sys_clk);
        ea_valid <= 1'b0;
        // Released qualifiers except ea_orig_upper and ea_mode show no stale value
        ea_value <= ~va;
        ea_write <= ~wr;
        ea_overflow <= 1'b0;
        ea_underflow <= 1'b0;
        ea_ps_write <= 1'b0;
    endtask
endmodule

// ===== verification/paged_data_space_address_extender_tb.sv
// Bench for the paged address extender: a table of CPU accesses, then
// register, interrupt and reset tests.
// Assumes the CPU model drives every ea_ input.
`timescale 1ns/1ns
`include "pdx_consts.svh"

module paged_data_space_address_extender_tb
    import pdx_pkg::*;
;
    logic        sys_clk;
    logic        srst;
    logic [4:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        ea_valid, ea_write, ea_orig_upper, ea_overflow, ea_underflow, ea_ps_write;
    logic [15:0] ea_value;
    pdx_mode_t   ea_mode;
    logic        mem_valid, mem_write, mem_psv, addr_trap, irq;
    logic [23:0] mem_addr;
    int          err_total = 0;
    int          n_checks = 0;
    int          cyc = 0;
    logic [31:0] q;

    typedef struct {
        logic [9:0]  rp, wp;
        logic        wr;
        logic [15:0] va;
        logic        up;
        pdx_mode_t   md;
        logic        ov, un, pgw, trap;
        logic [23:0] addr;
        logic        pw;
        logic [9:0]  rpa, wpa;
    } pdx_tb_row_t;

    // rp wp wr addr up mode ov un pgw trap out win rp_after wp_after
    pdx_tb_row_t rows [22] = '{
        '{10'h002, 10'h003, 0, 16'h8004, 1, PDX_MODE_INDIRECT, 0, 0, 0, 0, 24'h010004, 0, 10'h002, 10'h003},
        '{10'h002, 10'h003, 1, 16'hffff, 1, PDX_MODE_INDIRECT, 0, 0, 0, 0, 24'h01ffff, 0, 10'h002, 10'h003},
        '{10'h005, 10'h005, 0, 16'h2fff, 0, PDX_MODE_DIRECT, 0, 0, 0, 0, 24'h002fff, 0, 10'h005, 10'h005},
        '{10'h005, 10'h005, 1, 16'h1234, 0, PDX_MODE_DIRECT, 0, 0, 0, 0, 24'h001234, 0, 10'h005, 10'h005},
        '{10'h001, 10'h001, 1, 16'h8000, 1, PDX_MODE_INDIRECT, 0, 0, 0, 0, 24'h008000, 0, 10'h001, 10'h001},
        '{10'h200, 10'h004, 0, 16'h8010, 1, PDX_MODE_INDIRECT, 0, 0, 0, 0, 24'h000010, 1, 10'h200, 10'h004},
        '{10'h3ff, 10'h004, 0, 16'hffff, 1, PDX_MODE_INDIRECT, 0, 0, 0, 0, 24'hffffff, 1, 10'h3ff, 10'h004},
        '{10'h200, 10'h004, 1, 16'h8010, 1, PDX_MODE_INDIRECT, 0, 0, 1, 1, 24'h000000, 0, 10'h200, 10'h004},
        '{10'h005, 10'h006, 0, 16'h0000, 1, PDX_MODE_PRE_MOD, 1, 0, 0, 0, 24'h030000, 0, 10'h006, 10'h006},
        '{10'h005, 10'h006, 1, 16'h0000, 1, PDX_MODE_POST_MOD, 1, 0, 0, 0, 24'h038000, 0, 10'h005, 10'h007},
        '{10'h005, 10'h006, 0, 16'h7ffe, 1, PDX_MODE_POST_MOD, 0, 1, 0, 0, 24'h027ffe, 0, 10'h004, 10'h006},
        '{10'h005, 10'h006, 0, 16'h0002, 1, PDX_MODE_REG_OFFSET, 1, 0, 0, 0, 24'h028002, 0, 10'h005, 10'h006},
        '{10'h005, 10'h006, 0, 16'h7ffe, 1, PDX_MODE_MODULO, 0, 1, 0, 0, 24'h02fffe, 0, 10'h005, 10'h006},
        '{10'h005, 10'h006, 1, 16'h0000, 1, PDX_MODE_BIT_REV, 1, 0, 0, 0, 24'h030000, 0, 10'h005, 10'h006},
        '{10'h005, 10'h006, 0, 16'h0000, 0, PDX_MODE_PRE_MOD, 1, 0, 0, 0, 24'h000000, 0, 10'h005, 10'h006},
        '{10'h1ff, 10'h006, 0, 16'h0000, 1, PDX_MODE_PRE_MOD, 1, 0, 0, 0, 24'h000000, 0, 10'h1ff, 10'h006},
        '{10'h005, 10'h1ff, 1, 16'h0000, 1, PDX_MODE_POST_MOD, 1, 0, 0, 0, 24'h000000, 0, 10'h005, 10'h1ff},
        '{10'h3ff, 10'h006, 0, 16'h0000, 1, PDX_MODE_PRE_MOD, 1, 0, 0, 0, 24'h000000, 0, 10'h3ff, 10'h006},
        '{10'h001, 10'h006, 0, 16'h7ffe, 1, PDX_MODE_POST_MOD, 0, 1, 0, 0, 24'h007ffe, 0, 10'h001, 10'h006},
        '{10'h200, 10'h006, 0, 16'h7ffe, 1, PDX_MODE_PRE_MOD, 0, 1, 0, 0, 24'h007ffe, 0, 10'h200, 10'h006},
        '{10'h2ff, 10'h006, 0, 16'h0000, 1, PDX_MODE_PRE_MOD, 1, 0, 0, 0, 24'h800000, 1, 10'h300, 10'h006},
        '{10'h300, 10'h006, 0, 16'h7ffe, 1, PDX_MODE_POST_MOD, 0, 1, 0, 0, 24'h7ffffe, 1, 10'h2ff, 10'h006}
    };

    pdx_addr_ext DUT (.sys_clk(sys_clk), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .ea_valid(ea_valid), .ea_write(ea_write), .ea_value(ea_value),
        .ea_orig_upper(ea_orig_upper), .ea_mode(ea_mode), .ea_overflow(ea_overflow),
        .ea_underflow(ea_underflow), .ea_ps_write(ea_ps_write), .mem_valid(mem_valid),
        .mem_write(mem_write), .mem_psv(mem_psv), .mem_addr(mem_addr),
        .addr_trap(addr_trap), .irq(irq));

    pdx_cpu_model u_cpu (.sys_clk(sys_clk), .ea_valid(ea_valid), .ea_write(ea_write),
        .ea_value(ea_value), .ea_orig_upper(ea_orig_upper), .ea_mode(ea_mode),
        .ea_overflow(ea_overflow), .ea_underflow(ea_underflow), .ea_ps_write(ea_ps_write));

    initial begin
        sys_clk = 1'b0;
        forever #50 sys_clk = ~sys_clk;
    end

    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask

    // Avalon cycle: hold everything until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge sys_clk);
        avs_read <= ~wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= d;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (n >= 20) chk("waitrequest", 32'(avs_waitrequest), 32'h0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            results();
        end
    end

    initial begin
        srst = 1'b1;
        avs_address = 5'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        bus(1'b0, `PDX_OFF_READ_PAGE, 32'h0, q);
        chk("rpage reset", q, 32'h1);
        bus(1'b0, `PDX_OFF_WRITE_PAGE, 32'h0, q);
        chk("wpage reset", q, 32'h1);
        chk("irq reset", 32'(irq), 32'h0);
        $display("reset values done");
        foreach (rows[i]) begin
            bus(1'b1, `PDX_OFF_READ_PAGE, 32'(rows[i].rp), q);
            bus(1'b1, `PDX_OFF_WRITE_PAGE, 32'(rows[i].wp), q);
            u_cpu.access(rows[i].wr, rows[i].va, rows[i].up, rows[i].md, rows[i].ov,
                         rows[i].un, rows[i].pgw);
            @(posedge sys_clk);
            chk("trap", 32'(addr_trap), 32'(rows[i].trap));
            chk("valid", 32'(mem_valid), 32'(!rows[i].trap));
            if (!rows[i].trap) begin
                chk("addr", 32'(mem_addr), 32'(rows[i].addr));
                chk("dir", 32'(mem_write), 32'(rows[i].wr));
                if (!rows[i].wr) chk("window", 32'(mem_psv), 32'(rows[i].pw));
            end
            @(posedge sys_clk);
            chk("pulse", 32'(addr_trap | mem_valid), 32'h0);
            bus(1'b0, `PDX_OFF_READ_PAGE, 32'h0, q);
            chk("rpage", q, 32'(rows[i].rpa));
            bus(1'b0, `PDX_OFF_WRITE_PAGE, 32'h0, q);
            chk("wpage", q, 32'(rows[i].wpa));
        end
        $display("access table done");
        bus(1'b0, `PDX_OFF_LAST_ADDR, 32'h0, q);
        chk("last addr", q, 32'h007ffffe);
        bus(1'b1, `PDX_OFF_LAST_ADDR, 32'h0, q);
        bus(1'b0, `PDX_OFF_LAST_ADDR, 32'h0, q);
        chk("last addr ro", q, 32'h007ffffe);
        bus(1'b1, 5'h14, 32'hffffffff, q);
        bus(1'b0, 5'h14, 32'h0, q);
        chk("unmapped", q, 32'h0);
        bus(1'b1, `PDX_OFF_READ_PAGE, 32'hffffffff, q);
        bus(1'b1, `PDX_OFF_WRITE_PAGE, 32'hffffffff, q);
        bus(1'b1, `PDX_OFF_READ_PAGE, 32'h0, q);
        bus(1'b1, `PDX_OFF_WRITE_PAGE, 32'h0, q);
        bus(1'b0, `PDX_OFF_READ_PAGE, 32'h0, q);
        chk("rpage width", q, 32'h3ff);
        bus(1'b0, `PDX_OFF_WRITE_PAGE, 32'h0, q);
        chk("wpage width", q, 32'h1ff);
        $display("register access done");
        bus(1'b0, `PDX_OFF_STATUS, 32'h0, q);
        chk("status", q, 32'h3);
        bus(1'b1, `PDX_OFF_STATUS, 32'h3, q);
        bus(1'b0, `PDX_OFF_STATUS, 32'h0, q);
        chk("w1c", q, 32'h0);
        u_cpu.access(1'b1, 16'h8000, 1'b1, PDX_MODE_INDIRECT, 1'b0, 1'b0, 1'b1);
        repeat (3) @(posedge sys_clk);
        chk("irq masked", 32'(irq), 32'h0);
        bus(1'b1, `PDX_OFF_MASK, 32'h1, q);
        repeat (3) @(posedge sys_clk);
        chk("irq", 32'(irq), 32'h1);
        bus(1'b1, `PDX_OFF_STATUS, 32'h1, q);
        repeat (3) @(posedge sys_clk);
        chk("irq clear", 32'(irq), 32'h0);
        $display("interrupt done");
        srst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        bus(1'b0, `PDX_OFF_READ_PAGE, 32'h0, q);
        chk("rpage rerun", q, 32'h1);
        bus(1'b0, `PDX_OFF_WRITE_PAGE, 32'h0, q);
        chk("wpage rerun", q, 32'h1);
        $display("second reset done");
        results();
    end
endmodule
